// ---- core/egs_consts.svh ----
`ifndef EGS_CONSTS_SVH
`define EGS_CONSTS_SVH

// Register byte offsets
`define EGS_A_GEAR_NUM    8'h00
`define EGS_A_GEAR_DEN    8'h04
`define EGS_A_MARKER_OFS  8'h08
`define EGS_A_STOP_THR    8'h0C
`define EGS_A_COIN_LVL    8'h10
`define EGS_A_COIN_WIDTH  8'h14
`define EGS_A_TORQUE_CAP  8'h18
`define EGS_A_CTRL        8'h1C
`define EGS_A_ENC_PPR     8'h20
`define EGS_A_BRAKE_SPEED 8'h24
`define EGS_A_LIVE        8'h28
`define EGS_A_INT_STAT    8'h2C
`define EGS_A_INT_MASK    8'h30
`define EGS_A_POS_CMD     8'h34
`define EGS_A_ABS_POS     8'h38

// Control register fields
`define EGS_CTRL_HOME     1:0
`define EGS_CTRL_BRAKE    3:2
`define EGS_CTRL_ENC      4
`define EGS_CTRL_DYN      5
`define EGS_CTRL_CYCLES   11:8

// Interrupt event bits
`define EGS_EV_ZERO       0
`define EGS_EV_ALARM      1
`define EGS_EV_STOP       2
`define EGS_EV_COIN       3

// Reset values and limits
`define EGS_RST_GEAR        15'h0001
`define EGS_RST_STOP_THR    12'h032
`define EGS_RST_COIN_WIDTH  12'h014
`define EGS_RST_TORQUE_CAP  10'h3E8
`define EGS_RST_BRAKE_SPEED 12'h00A
`define EGS_RST_CYCLES      4'h1
`define EGS_RST_PPR         16'h2EE0
`define EGS_CYCLE_COUNTS    18'h02EE0
`define EGS_OFS_MAX         14'h2EDF

`endif

// ---- core/egs_pkg.sv ----
package egs_pkg;

  // Brake sequencer states
  typedef enum logic [1:0] {
    BRK_RUN,
    BRK_DECEL,
    BRK_HOLD,
    BRK_COAST
  } egs_brake_e;

  // Measured and commanded speed, r/min
  typedef struct packed {
    logic [11:0] meas;
    logic [11:0] cmd;
  } egs_speed_s;

  // Whole state of the servo logic
  typedef struct packed {
    logic [14:0]        num;
    logic [14:0]        den;
    logic [14:0]        numSh;
    logic [14:0]        denSh;
    logic [13:0]        ofs;
    logic [11:0]        stopThr;
    logic [11:0]        coinLvl;
    logic [11:0]        coinWidth;
    logic [11:0]        brakeSpeed;
    logic [9:0]         cap;
    logic [1:0]         home;
    logic [1:0]         brakeMode;
    logic               encFit;
    logic               dynFit;
    logic [3:0]         cycles;
    logic [15:0]        ppr;
    logic signed [23:0] cmdAcc;
    logic signed [31:0] posCmd;
    logic signed [23:0] fbAcc;
    logic [1:0]         quad;
    logic [17:0]        elecAngle;
    logic [17:0]        revAngle;
    logic signed [31:0] absPos;
    logic               started;
    logic               setZeroD;
    egs_brake_e         brk;
    logic [3:0]         intStat;
    logic [3:0]         intMask;
    logic [31:0]        rdata;
    logic               zeroPulse;
    logic               stopped;
    logic               match;
    logic [9:0]         torque;
    logic               markerStop;
    logic               brakeOn;
    logic               maxDecel;
    logic               dynBrake;
    logic               irq;
  } egs_state_s;

endpackage

// ---- core/egs_gear_servo.sv ----
// What this block does
// [R01] Command pulses scaled by numerator over denominator into position counts.
// [R02] Counts per revolution: resolver cycles times 12000, or encoder PPR.
// [R03] Feedback counts scaled by denominator over numerator onto output pulse pair.
// [R04] New gear ratio values apply only at a power-up parameter load.
// [R05] Electrical zero shifted by marker offset, 0 to 11999 counts.
// [R06] One electrical zero per resolver cycle.
// [R07] Operator sets offset to displayed angle times 12000 over 360.
// [R08] Shifted zero drives zero pulse output and stop-at-marker position.
// [R09] Motor stopped output while speed below threshold, default 50 r/min.
// [R10] Non-zero match level: coincidence when speed reaches that level.
// [R11] Zero match level: coincidence when speed reaches commanded speed.
// [R12] Coincidence uses a tolerance window, default 20 r/min.
// [R13] Under torque limiting, torque clamped to cap, default 100 percent.
// [R14] Set-zero or startup applies home mode 0, 1 or 2.
// [R15] Enable off runs brake sequence; alarm applies brake at once.
// [R16] Brake mode 0: no mechanical brake, coast or dynamic brake.
// [R17] Modes 1, 2: max decel, then hold brake at engage speed.
// [R18] Division remainders carried forward so no counts are lost.
//
// Chosen here: strobed register access and the address map.
`include "egs_consts.svh"

module egs_gear_servo
  import egs_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  // Command pulses, A counts up, B counts down
  input  wire logic        cmd_pulse_a,
  input  wire logic        cmd_pulse_b,
  // Internal feedback count
  input  wire logic        fbStep,
  input  wire logic        fbDir,
  // Power-up parameter load
  input  wire logic        paramLoad,
  // Speed, torque and machine inputs
  input  wire egs_speed_s  speedIn,
  input  wire logic [9:0]  torqueReq,
  input  wire logic        torqueLimitIn,
  input  wire logic        setZero,
  input  wire logic        enable,
  input  wire logic        alarm,
  input  wire logic        stopAtMarker,
  // Encoder-equivalent outputs
  output logic             out_pulse_a,
  output logic             out_pulse_b,
  output logic             out_zero_pulse,
  // Status and drive outputs
  output logic             motorStopped,
  output logic             speedMatch,
  output logic      [9:0]  torqueOut,
  output logic             markerStop,
  output logic             brakeOn,
  output logic             maxDecel,
  output logic             dynBrake,
  output logic             irq
);

  egs_state_s         r;
  egs_state_s         n;
  logic signed [23:0] numS;
  logic signed [23:0] denS;
  logic signed [23:0] cmdSum;
  logic signed [23:0] fbSum;
  logic [17:0]        cycCounts;
  logic [17:0]        countsPerRev;
  logic [11:0]        target;
  logic [11:0]        diff;
  logic [3:0]         ev;
  logic [3:0]         clr;
  logic               zeroReq;

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    n = r;
    numS = $signed({9'h000, r.num});
    denS = $signed({9'h000, r.den});
    ev = 4'h0;
    clr = 4'h0;
    // [R02] Resolution per revolution
    cycCounts = r.encFit ? {2'h0, r.ppr} : `EGS_CYCLE_COUNTS;
    countsPerRev = r.encFit ? {2'h0, r.ppr} : 18'(18'(r.cycles) * `EGS_CYCLE_COUNTS);

    // [R01] Command gearing
    cmdSum = r.cmdAcc + (cmd_pulse_a ? numS : 24'sh0) - (cmd_pulse_b ? numS : 24'sh0);
    // [R18] Remainder kept; one count drained per cycle
    if (cmdSum >= denS) begin
      n.cmdAcc = cmdSum - denS;
      n.posCmd = r.posCmd + 32'sh1;
    end else if (cmdSum <= -denS) begin
      n.cmdAcc = cmdSum + denS;
      n.posCmd = r.posCmd - 32'sh1;
    end else begin
      n.cmdAcc = cmdSum;
    end

    // [R03] Feedback gearing onto quadrature pair
    fbSum = r.fbAcc + (fbStep ? (fbDir ? denS : -denS) : 24'sh0);
    // [R18] Feedback remainder carried
    if (fbSum >= numS) begin
      n.fbAcc = fbSum - numS;
      n.quad = {r.quad[0], ~r.quad[1]};
    end else if (fbSum <= -numS) begin
      n.fbAcc = fbSum + numS;
      n.quad = {~r.quad[0], r.quad[1]};
    end else begin
      n.fbAcc = fbSum;
    end

    // [R06] Electrical angle wraps once per resolver cycle
    if (fbStep) begin
      if (fbDir) begin
        n.elecAngle = (r.elecAngle >= cycCounts - 18'h00001) ? 18'h00000
                                                              : r.elecAngle + 18'h00001;
        n.revAngle = (r.revAngle >= countsPerRev - 18'h00001) ? 18'h00000
                                                               : r.revAngle + 18'h00001;
        n.absPos = r.absPos + 32'sh1;
      end else begin
        n.elecAngle = (r.elecAngle == 18'h00000) ? cycCounts - 18'h00001
                                                 : r.elecAngle - 18'h00001;
        n.revAngle = (r.revAngle == 18'h00000) ? countsPerRev - 18'h00001
                                               : r.revAngle - 18'h00001;
        n.absPos = r.absPos - 32'sh1;
      end
    end

    // [R08] Zero pulse at shifted zero, also stop point
    n.zeroPulse = fbStep && (n.elecAngle == {4'h0, r.ofs});
    if (!stopAtMarker) begin
      n.markerStop = 1'b0;
    end else if (n.zeroPulse) begin
      n.markerStop = 1'b1;
    end
    ev[`EGS_EV_ZERO] = n.zeroPulse;

    // [R14] Home processing on set-zero edge or first cycle after reset
    zeroReq = (setZero && !r.setZeroD) || !r.started;
    n.started = 1'b1;
    n.setZeroD = setZero;
    if (zeroReq) begin
      case (r.home)
        2'h0: begin
          n.absPos = 32'sh0;
        end
        2'h1: begin
          n.absPos = $signed({14'h0000, n.revAngle});
        end
        default: begin
        end
      endcase
    end

    // [R09] Stopped comparator
    n.stopped = speedIn.meas < r.stopThr;
    // [R10] [R11] Coincidence target
    target = (r.coinLvl != 12'h000) ? r.coinLvl : speedIn.cmd;
    diff = (speedIn.meas >= target) ? speedIn.meas - target : target - speedIn.meas;
    // [R12] Tolerance window
    n.match = diff <= r.coinWidth;
    ev[`EGS_EV_STOP] = n.stopped && !r.stopped;
    ev[`EGS_EV_COIN] = n.match && !r.match;

    // [R13] Torque clamp
    n.torque = (torqueLimitIn && torqueReq > r.cap) ? r.cap : torqueReq;

    // [R15] Brake sequencer; alarm overrides from every state
    case (r.brk)
      BRK_RUN: begin
        if (!enable) begin
          // [R16] Mode 0 coasts
          n.brk = (r.brakeMode == 2'h0) ? BRK_COAST : BRK_DECEL;
        end
      end
      BRK_DECEL: begin
        if (enable) begin
          n.brk = BRK_RUN;
        // [R17] Hold brake at engage speed
        end else if (speedIn.meas <= r.brakeSpeed) begin
          n.brk = BRK_HOLD;
        end
      end
      BRK_HOLD, BRK_COAST: begin
        if (enable) begin
          n.brk = BRK_RUN;
        end
      end
      default: begin
        n.brk = BRK_HOLD;
      end
    endcase
    // [R15] Alarm brakes at once
    if (alarm) begin
      n.brk = BRK_HOLD;
    end
    ev[`EGS_EV_ALARM] = alarm && (r.brk != BRK_HOLD);
    n.brakeOn = n.brk == BRK_HOLD;
    n.maxDecel = n.brk == BRK_DECEL;
    n.dynBrake = (n.brk == BRK_COAST) && r.dynFit;

    // [R04] Gear ratio applied only at parameter load
    if (paramLoad) begin
      n.num = r.numSh;
      n.den = r.denSh;
      // Acts as a power cycle: a remainder of the old ratio could overflow the new one
      n.cmdAcc = 24'sh0;
      n.fbAcc = 24'sh0;
    end

    // Register writes; zero gear terms forced to one to keep division bounded
    if (regWrite) begin
      case (regAddr)
        `EGS_A_GEAR_NUM: begin
          n.numSh = (regWdata[14:0] == 15'h0000) ? `EGS_RST_GEAR : regWdata[14:0];
        end
        `EGS_A_GEAR_DEN: begin
          n.denSh = (regWdata[14:0] == 15'h0000) ? `EGS_RST_GEAR : regWdata[14:0];
        end
        // [R05] Offset limited to one cycle
        `EGS_A_MARKER_OFS: begin
          n.ofs = (regWdata[13:0] > `EGS_OFS_MAX) ? `EGS_OFS_MAX : regWdata[13:0];
        end
        `EGS_A_STOP_THR:    n.stopThr = regWdata[11:0];
        `EGS_A_COIN_LVL:    n.coinLvl = regWdata[11:0];
        `EGS_A_COIN_WIDTH:  n.coinWidth = regWdata[11:0];
        `EGS_A_TORQUE_CAP:  n.cap = regWdata[9:0];
        `EGS_A_BRAKE_SPEED: n.brakeSpeed = regWdata[11:0];
        `EGS_A_CTRL: begin
          n.home = regWdata[`EGS_CTRL_HOME];
          n.brakeMode = regWdata[`EGS_CTRL_BRAKE];
          n.encFit = regWdata[`EGS_CTRL_ENC];
          n.dynFit = regWdata[`EGS_CTRL_DYN];
          n.cycles = (regWdata[`EGS_CTRL_CYCLES] == 4'h0) ? `EGS_RST_CYCLES
                                                         : regWdata[`EGS_CTRL_CYCLES];
        end
        `EGS_A_ENC_PPR: begin
          n.ppr = (regWdata[15:0] == 16'h0000) ? `EGS_RST_PPR : regWdata[15:0];
        end
        `EGS_A_INT_STAT:    clr = regWdata[3:0];
        `EGS_A_INT_MASK:    n.intMask = regWdata[3:0];
        default: begin
        end
      endcase
    end

    // Sticky status, a new event wins over a clear in the same cycle
    n.intStat = (r.intStat & ~clr) | ev;
    n.irq = |(n.intStat & n.intMask);

    // Read data valid in the cycle after the strobe only
    n.rdata = 32'h00000000;
    if (regRead) begin
      case (regAddr)
        `EGS_A_GEAR_NUM:    n.rdata = {17'h00000, r.numSh};
        `EGS_A_GEAR_DEN:    n.rdata = {17'h00000, r.denSh};
        `EGS_A_MARKER_OFS:  n.rdata = {18'h00000, r.ofs};
        `EGS_A_STOP_THR:    n.rdata = {20'h00000, r.stopThr};
        `EGS_A_COIN_LVL:    n.rdata = {20'h00000, r.coinLvl};
        `EGS_A_COIN_WIDTH:  n.rdata = {20'h00000, r.coinWidth};
        `EGS_A_TORQUE_CAP:  n.rdata = {22'h000000, r.cap};
        `EGS_A_BRAKE_SPEED: n.rdata = {20'h00000, r.brakeSpeed};
        `EGS_A_CTRL: begin
          n.rdata = {20'h00000, r.cycles, 2'h0, r.dynFit, r.encFit, r.brakeMode, r.home};
        end
        `EGS_A_ENC_PPR:     n.rdata = {16'h0000, r.ppr};
        `EGS_A_LIVE: begin
          n.rdata = {24'h000000, r.brk, r.markerStop, r.match, r.stopped, r.brakeOn,
                     r.quad};
        end
        `EGS_A_INT_STAT:    n.rdata = {28'h0000000, r.intStat};
        `EGS_A_INT_MASK:    n.rdata = {28'h0000000, r.intMask};
        `EGS_A_POS_CMD:     n.rdata = r.posCmd;
        `EGS_A_ABS_POS:     n.rdata = r.absPos;
        default:            n.rdata = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register, constants only under reset
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
      r.num <= `EGS_RST_GEAR;
      r.den <= `EGS_RST_GEAR;
      r.numSh <= `EGS_RST_GEAR;
      r.denSh <= `EGS_RST_GEAR;
      r.stopThr <= `EGS_RST_STOP_THR;
      r.coinWidth <= `EGS_RST_COIN_WIDTH;
      r.cap <= `EGS_RST_TORQUE_CAP;
      r.brakeSpeed <= `EGS_RST_BRAKE_SPEED;
      r.cycles <= `EGS_RST_CYCLES;
      r.ppr <= `EGS_RST_PPR;
      r.brk <= BRK_HOLD;
      r.brakeOn <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign regRdata = r.rdata;
  assign out_pulse_a = r.quad[0];
  assign out_pulse_b = r.quad[1];
  assign out_zero_pulse = r.zeroPulse;
  assign motorStopped = r.stopped;
  assign speedMatch = r.match;
  assign torqueOut = r.torque;
  assign markerStop = r.markerStop;
  assign brakeOn = r.brakeOn;
  assign maxDecel = r.maxDecel;
  assign dynBrake = r.dynBrake;
  assign irq = r.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_gear_hold: assert property (@(posedge clock) disable iff (sys_rst) // [R04]
    !paramLoad |=> (r.num == $past(r.num)) && (r.den == $past(r.den)))
    else $error("gear ratio changed without parameter load");
  a_cmd_unit: assert property (@(posedge clock) disable iff (sys_rst) // [R01]
    (cmd_pulse_a && !cmd_pulse_b && r.num == r.den && r.cmdAcc == 24'sh0)
      |=> r.posCmd == $past(r.posCmd) + 32'sh1)
    else $error("unity gear pulse not counted");
  a_cmd_remain: assert property (@(posedge clock) disable iff (sys_rst) // [R18]
    (r.num <= r.den) |-> (r.cmdAcc < denS) && (r.cmdAcc > -denS))
    else $error("command remainder out of range");
  a_zero_offset: assert property (@(posedge clock) disable iff (sys_rst) // [R08]
    out_zero_pulse |-> r.elecAngle == {4'h0, $past(r.ofs)})
    else $error("zero pulse away from shifted zero");
  // The first edge after release still resets the state, so skip it
  a_stop_level: assert property (@(posedge clock) disable iff (sys_rst) // [R09]
    !$past(sys_rst) |-> motorStopped == ($past(speedIn.meas) < $past(r.stopThr)))
    else $error("stopped output wrong");
  a_coin_level: assert property (@(posedge clock) disable iff (sys_rst) // [R10]
    (r.coinLvl != 12'h000 && speedIn.meas == r.coinLvl) |=> speedMatch)
    else $error("coincidence missed at level");
  a_torque_cap: assert property (@(posedge clock) disable iff (sys_rst) // [R13]
    torqueLimitIn |=> torqueOut <= $past(r.cap))
    else $error("torque above cap");
  a_alarm_brake: assert property (@(posedge clock) disable iff (sys_rst) // [R15]
    alarm |=> brakeOn && !maxDecel)
    else $error("alarm did not brake at once");
  a_coast_free: assert property (@(posedge clock) disable iff (sys_rst) // [R16]
    (r.brk == BRK_RUN && !enable && !alarm && r.brakeMode == 2'h0)
      |=> !brakeOn ##1 (!brakeOn || $past(alarm)))
    else $error("brake applied in mode 0");
  a_decel_hold: assert property (@(posedge clock) disable iff (sys_rst) // [R17]
    (r.brk == BRK_DECEL && !enable && speedIn.meas <= r.brakeSpeed) |=> brakeOn)
    else $error("holding brake not engaged");
  a_home_clear: assert property (@(posedge clock) disable iff (sys_rst) // [R14]
    (setZero && !r.setZeroD && r.home == 2'h0) |=> r.absPos == 32'sh0)
    else $error("home mode 0 did not clear position");

endmodule

// ---- tb/egs_cmd_source.sv ----
module egs_cmd_source (
  // Clock
  input  wire logic clock,
  // Command pulses towards the drive
  output logic      cmd_pulse_a,
  output logic      cmd_pulse_b
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle low from time zero
  initial begin
    cmd_pulse_a = 1'b0;
    cmd_pulse_b = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle pulses; gap 0 gives a count every cycle, larger gaps a slow train
  task automatic send(input int n, input logic up, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      cmd_pulse_a <= up;
      cmd_pulse_b <= !up;
      if (gap > 0) begin
        @(posedge clock);
        cmd_pulse_a <= 1'b0;
        cmd_pulse_b <= 1'b0;
        repeat (gap - 1) @(posedge clock);
      end
    end
    @(posedge clock);
    cmd_pulse_a <= 1'b0;
    cmd_pulse_b <= 1'b0;
  endtask
endmodule

// ---- tb/test_egs_gear_servo.sv ----
`include "egs_consts.svh"

module test_egs_gear_servo
  import egs_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock;
  logic        sys_rst;
  logic [7:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWrite;
  logic        regRead;
  logic [31:0] regRdata;
  logic        cmd_pulse_a;
  logic        cmd_pulse_b;
  logic        fbStep;
  logic        fbDir;
  logic        paramLoad;
  egs_speed_s  speedIn;
  logic [9:0]  torqueReq;
  logic        torqueLimitIn;
  logic        setZero;
  logic        enable;
  logic        alarm;
  logic        stopAtMarker;
  logic        out_pulse_a;
  logic        out_pulse_b;
  logic        out_zero_pulse;
  logic        motorStopped;
  logic        speedMatch;
  logic [9:0]  torqueOut;
  logic        markerStop;
  logic        brakeOn;
  logic        maxDecel;
  logic        dynBrake;
  logic        irq;
  int          fails;
  int          compares;
  int          zeroCnt;
  int          qEdges;
  logic        prevA;
  logic        prevB;

  egs_gear_servo dut_u (.clock(clock), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .cmd_pulse_a(cmd_pulse_a), .cmd_pulse_b(cmd_pulse_b), .fbStep(fbStep), .fbDir(fbDir),
    .paramLoad(paramLoad), .speedIn(speedIn), .torqueReq(torqueReq),
    .torqueLimitIn(torqueLimitIn), .setZero(setZero), .enable(enable), .alarm(alarm),
    .stopAtMarker(stopAtMarker), .out_pulse_a(out_pulse_a), .out_pulse_b(out_pulse_b),
    .out_zero_pulse(out_zero_pulse), .motorStopped(motorStopped), .speedMatch(speedMatch),
    .torqueOut(torqueOut), .markerStop(markerStop), .brakeOn(brakeOn),
    .maxDecel(maxDecel), .dynBrake(dynBrake), .irq(irq));

  egs_cmd_source src_u (.clock(clock), .cmd_pulse_a(cmd_pulse_a), .cmd_pulse_b(cmd_pulse_b));

  // Free-running 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Count zero pulses and quadrature steps; a step changes one line at a time
  always @(posedge clock) begin
    if (out_zero_pulse === 1'b1) zeroCnt++;
    if (out_pulse_a !== prevA || out_pulse_b !== prevB) qEdges++;
    prevA = out_pulse_a;
    prevB = out_pulse_b;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("Compares %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chkv(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic chkb(input string what, input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // Waits, then steps off the edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic regWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic regRd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask

  task automatic spd(input logic [11:0] m, input logic [11:0] c);
    @(posedge clock);
    speedIn.meas <= m;
    speedIn.cmd  <= c;
    cyc(3);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  task automatic t_reset();
    logic [31:0] d;
    regRd(`EGS_A_GEAR_DEN, d);
    chkv("den reset", d, 32'h0000_0001);
    regRd(`EGS_A_STOP_THR, d);
    chkv("stop thr reset", d, 32'h0000_0032);
    regRd(`EGS_A_COIN_WIDTH, d);
    chkv("width reset", d, 32'h0000_0014);
    regRd(`EGS_A_TORQUE_CAP, d);
    chkv("cap reset", d, 32'h0000_03E8);
    regRd(8'hFC, d);
    chkv("unmapped read", d, 32'h0000_0000);
    chkb("brake at reset", brakeOn, 1'b1);
    $display("Test reset done");
  endtask

  task automatic t_feedback();
    logic [31:0] d;
    regWr(`EGS_A_MARKER_OFS, 32'h0000_FFFF);
    regRd(`EGS_A_MARKER_OFS, d);
    chkv("offset clamp", d, 32'h0000_2EDF);
    regWr(`EGS_A_MARKER_OFS, 32'(90 * 12000 / 360));
    regWr(`EGS_A_CTRL, 32'h0000_0200);
    stopAtMarker <= 1'b1;
    zeroCnt = 0;
    qEdges  = 0;
    fbDir  <= 1'b1;
    fbStep <= 1'b1;
    repeat (36007) @(posedge clock);
    fbStep <= 1'b0;
    cyc(3);
    chkv("zero pulses", 32'(zeroCnt), 32'h0000_0003);
    chkv("quad steps", 32'(qEdges), 32'h0000_8CA7);
    chkb("marker stop", markerStop, 1'b1);
    regRd(`EGS_A_ABS_POS, d);
    chkv("abs pos", d, 32'h0000_8CA7);
    @(posedge clock);
    stopAtMarker <= 1'b0;
    cyc(3);
    chkb("marker stop drop", markerStop, 1'b0);
    $display("Test feedback done");
  endtask

  // home modes 2, 1, 0 in turn
  task automatic t_home();
    logic [31:0] d;
    logic [31:0] homeExp [3] = '{32'h0000_0000, 32'h0000_2EE7, 32'h0000_8CA7};
    for (int m = 2; m >= 0; m--) begin
      regWr(`EGS_A_CTRL, 32'h0000_0200 | 32'(m));
      setZero <= 1'b1;
      @(posedge clock);
      setZero <= 1'b0;
      cyc(3);
      regRd(`EGS_A_ABS_POS, d);
      chkv("home result", d, homeExp[m]);
    end
    $display("Test home done");
  endtask

  task automatic t_gear();
    logic [31:0] d;
    regWr(`EGS_A_GEAR_NUM, 32'h0000_0003);
    regWr(`EGS_A_GEAR_DEN, 32'h0000_0002);
    src_u.send(2, 1'b1, 0);
    regRd(`EGS_A_POS_CMD, d);
    chkv("before load", d, 32'h0000_0002);
    @(posedge clock);
    paramLoad <= 1'b1;
    @(posedge clock);
    paramLoad <= 1'b0;
    src_u.send(1, 1'b1, 0);
    cyc(4);
    regRd(`EGS_A_POS_CMD, d);
    chkv("one pulse", d, 32'h0000_0003);
    src_u.send(1, 1'b1, 5);
    cyc(4);
    regRd(`EGS_A_POS_CMD, d);
    chkv("remainder", d, 32'h0000_0005);
    src_u.send(4, 1'b1, 0);
    src_u.send(2, 1'b0, 3);
    cyc(12);
    regRd(`EGS_A_POS_CMD, d);
    chkv("burst and down", d, 32'h0000_0008);
    @(posedge clock);
    qEdges = 0;
    fbDir  <= 1'b1;
    fbStep <= 1'b1;
    repeat (6) @(posedge clock);
    fbStep <= 1'b0;
    cyc(4);
    chkv("scaled output", 32'(qEdges), 32'h0000_0004);
    $display("Test gear done");
  endtask

  task automatic t_speed();
    spd(12'h031, 12'h000);
    chkb("stopped 49", motorStopped, 1'b1);
    spd(12'h032, 12'h000);
    chkb("stopped 50", motorStopped, 1'b0);
    spd(12'h3FC, 12'h3E8);
    chkb("match cmd +20", speedMatch, 1'b1);
    spd(12'h3FD, 12'h3E8);
    chkb("match cmd +21", speedMatch, 1'b0);
    regWr(`EGS_A_COIN_LVL, 32'h0000_01F4);
    spd(12'h1F4, 12'h000);
    chkb("match lvl exact", speedMatch, 1'b1);
    spd(12'h1E0, 12'h3E8);
    chkb("match lvl -20", speedMatch, 1'b1);
    spd(12'h1DF, 12'h3E8);
    chkb("match lvl -21", speedMatch, 1'b0);
    $display("Test speed done");
  endtask

  task automatic t_torque();
    regWr(`EGS_A_TORQUE_CAP, 32'h0000_0258);
    torqueReq     <= 10'h384;
    torqueLimitIn <= 1'b1;
    cyc(3);
    chkv("clamped", 32'(torqueOut), 32'h0000_0258);
    @(posedge clock);
    torqueLimitIn <= 1'b0;
    cyc(3);
    chkv("unclamped", 32'(torqueOut), 32'h0000_0384);
    $display("Test torque done");
  endtask

  // brake sequences, alarm and its interrupt
  task automatic t_brake();
    logic [31:0] d;
    regWr(`EGS_A_CTRL, 32'h0000_0220);
    spd(12'h3E8, 12'h000);
    @(posedge clock);
    enable <= 1'b1;
    cyc(3);
    chkb("run brake", brakeOn, 1'b0);
    @(posedge clock);
    enable <= 1'b0;
    cyc(3);
    chkb("dyn brake", dynBrake, 1'b1);
    chkb("coast no brake", brakeOn, 1'b0);
    for (int m = 1; m <= 2; m++) begin
      regWr(`EGS_A_CTRL, 32'h0000_0200 | 32'(m << 2));
      spd(12'h3E8, 12'h000);
      @(posedge clock);
      enable <= 1'b1;
      cyc(3);
      @(posedge clock);
      enable <= 1'b0;
      cyc(3);
      chkb("max decel", maxDecel, 1'b1);
      chkb("decel no brake", brakeOn, 1'b0);
      spd(12'h00A, 12'h000);
      chkb("hold at speed", brakeOn, 1'b1);
    end
    @(posedge clock);
    enable <= 1'b1;
    cyc(3);
    @(posedge clock);
    alarm <= 1'b1;
    cyc(1);
    chkb("alarm brake", brakeOn, 1'b1);
    cyc(2);
    chkb("irq masked", irq, 1'b0);
    regWr(`EGS_A_INT_MASK, 32'h0000_0002);
    cyc(2);
    chkb("irq raised", irq, 1'b1);
    regRd(`EGS_A_INT_STAT, d);
    chkb("alarm status", d[`EGS_EV_ALARM], 1'b1);
    @(posedge clock);
    alarm <= 1'b0;
    regWr(`EGS_A_INT_STAT, 32'h0000_0002);
    cyc(2);
    chkb("irq cleared", irq, 1'b0);
    $display("Test brake done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; reset held for six cycles
  initial begin
    sys_rst = 1'b1;
    regAddr = 8'h00;
    regWdata = 32'h0000_0000;
    regWrite = 1'b0;
    regRead = 1'b0;
    fbStep = 1'b0;
    fbDir = 1'b0;
    paramLoad = 1'b0;
    speedIn = '0;
    torqueReq = 10'h000;
    torqueLimitIn = 1'b0;
    setZero = 1'b0;
    enable = 1'b0;
    alarm = 1'b0;
    stopAtMarker = 1'b0;
    fails = 0;
    compares = 0;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    cyc(2);
    t_reset();
    t_feedback();
    t_home();
    t_gear();
    t_speed();
    t_torque();
    t_brake();
    wrap_up();
  end

  // Watchdog: the tests need about 36300 cycles
  initial begin
    #(80000 * 8);
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule
